// *** hw/fieldbus_slave_pkg.sv ***
// Purpose: shared constants for the fieldbus slave poll/io block
// Assumes: 125 MHz clk, Avalon-MM register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package fieldbus_slave_pkg;
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h08;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h0C;
  localparam logic [5:0] ADDR_POSITION = 6'h10;
  localparam logic [5:0] ADDR_LAST_CTRL = 6'h14;
  localparam logic [5:0] ADDR_WD_TIME = 6'h18;
  localparam logic [5:0] ADDR_DEVICE_TYPE = 6'h1C;
  localparam logic [5:0] ADDR_ATTR = 6'h20;

  // message kinds as decoded by the frame layer
  localparam logic [2:0] MSG_POLL = 3'h0;
  localparam logic [2:0] MSG_OPEN = 3'h1;
  localparam logic [2:0] MSG_CLOSE = 3'h2;
  localparam logic [2:0] MSG_ATTR_RD = 3'h3;
  localparam logic [2:0] MSG_ATTR_WR = 3'h4;

  localparam logic [1:0] GROUP_1 = 2'h1;
  localparam logic [1:0] GROUP_2 = 2'h2;

  // control byte bit positions
  localparam int BIT_PRESET = 0;
  localparam int BIT_EMIT_OFF = 1;
  localparam int BIT_EMIT_ON = 2;
  localparam int BIT_FAULT_ACK = 3;

  // interrupt/status bit positions
  localparam int IRQ_CONNECT = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_CTRL_EVENT = 2;
  localparam int IRQ_CAN_FAULT = 3;
  localparam int IRQ_BAD_CTRL = 4;
  localparam int IRQ_ATTR = 5;
  localparam int IRQ_BITS = 6;

  localparam logic [31:0] WD_TIME_RST = 32'h0000_0000;
  localparam logic [7:0] ATTR_OK = 8'h00;
  localparam logic [7:0] ATTR_REFUSED = 8'h14;

  localparam int CLK_MHZ = 125;
  localparam int DUP_CHECK_MS = 1;
  localparam int DUP_CHECK_CYC = DUP_CHECK_MS * 1000 * CLK_MHZ;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int CAN_WD_US = 100;
  localparam int CAN_WD_CYC = CAN_WD_US * CLK_MHZ;
endpackage

// *** hw/edge_sync.sv ***
// Purpose: two-flop synchroniser bank for asynchronous pin inputs
// Assumes: inputs are quasi-static or slow compared with clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // refused at elaboration: a zero-width bank has nothing to carry
  if (WIDTH < 1)
    $error("edge_sync needs WIDTH of at least 1");

  always_comb
  begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.stable;
endmodule

// *** hw/fieldbus_slave_poll_io.sv ***
// Purpose: slave message handling, poll i/o, watchdogs and indicators
// Assumes: frame layer delivers decoded messages as one-cycle strobes
// Notes: registers on Avalon-MM; one level irq output
// Operation
// - slave only; group 2 in, group 1 poll reply
// - connections opened and closed by unconnected requests
// - poll watchdog drops connection, red flashes
// - watchdog supervises the protocol controller
// - answer each addressed poll while connected with one response
// - duplicate address check before going online
// - execute attribute requests, return outcome response
// - indicators reflect offline, run, fault, hardware ok
// - response is 4 bytes, little-endian, msb holds error
// - control byte bits preset, off, on, ack
// - programming data exchanged in binary
// - ack clears error report, persisting error resets it
// - node address from six switches, switch 1 lsb
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module fieldbus_slave_poll_io #(
  parameter int DUP_CHECK_CYCLES = fieldbus_slave_pkg::DUP_CHECK_CYC,
  parameter int FLASH_CYCLES = fieldbus_slave_pkg::FLASH_CYC,
  parameter int CAN_WD_CYCLES = fieldbus_slave_pkg::CAN_WD_CYC,
  parameter logic [7:0] DEVICE_TYPE = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [5:0] address_switch,
  input wire logic msg_valid,
  input wire logic [1:0] msg_group,
  input wire logic [5:0] msg_dest,
  input wire logic [2:0] msg_kind,
  input wire logic [7:0] msg_data,
  input wire logic can_alive,
  input wire logic dup_detected,
  input wire logic [31:0] position,
  input wire logic error_active,
  output logic tx_valid,
  output logic [1:0] tx_group,
  output logic [2:0] tx_kind,
  output logic [31:0] tx_data,
  output logic dup_check_tx,
  output logic preset_pulse,
  output logic emitter_off_request,
  output logic emitter_on_request,
  output logic fault_acknowledge,
  output logic [5:0] node_address,
  output logic led_run,
  output logic led_err,
  output logic led_ok,
  output logic irq
);
  localparam int IRQ_W = fieldbus_slave_pkg::IRQ_BITS;

  typedef enum logic [2:0] {
    ST_DUP_CHECK, ST_ONLINE, ST_CONNECTED, ST_TIMEOUT, ST_FAULT
  } link_state_t;

  typedef struct packed {
    link_state_t link;
    logic [31:0] dup_cnt;
    logic [31:0] wd_cnt;
    logic [31:0] can_cnt;
    logic [31:0] flash_cnt;
    logic flash;
    logic [3:0] last_ctrl;
    logic err_report;
    logic [31:0] wd_time;
    logic auto_ack;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] attr_value;
    logic ack;
    logic [31:0] rdata;
    logic tx_valid;
    logic [1:0] tx_group;
    logic [2:0] tx_kind;
    logic [31:0] tx_data;
    logic dup_tx;
    logic [3:0] pulses;
    logic [5:0] node;
    logic run;
    logic err;
    logic ok;
    logic irq;
  } core_t;

  core_t s;
  core_t n;
  logic [7:0] sw_sync;
  logic [1:0] pin_sync;

  if (DUP_CHECK_CYCLES < 1 || FLASH_CYCLES < 1 || CAN_WD_CYCLES < 1)
    $error("cycle counts must be at least 1");

  // switches and status pins come from outside the clock domain
  edge_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({dup_detected, can_alive, address_switch}),
    .sync_out(sw_sync)
  );
  assign pin_sync = sw_sync[7:6];

  always_comb
  begin
    logic [3:0] ctrl;
    logic [3:0] rise;
    logic [IRQ_W-1:0] ev;
    logic addressed;
    logic bus_req;
    ctrl = '0;
    rise = '0;
    ev = '0;
    addressed = msg_valid && msg_dest == s.node;
    bus_req = (avs_read || avs_write) && !s.ack;
    n = s;
    n.tx_valid = 1'b0;
    n.dup_tx = 1'b0;
    n.pulses = '0;
    n.ack = 1'b0;
    n.node = sw_sync[5:0];

    // indicator flash divider
    if (s.flash_cnt >= 32'(FLASH_CYCLES - 1))
    begin
      n.flash_cnt = '0;
      n.flash = !s.flash;
    end
    else
      n.flash_cnt = s.flash_cnt + 32'h0000_0001;

    // protocol controller supervision: needs a sign of life
    if (pin_sync[0])
      n.can_cnt = '0;
    else if (s.can_cnt < 32'(CAN_WD_CYCLES))
      n.can_cnt = s.can_cnt + 32'h0000_0001;
    if (s.can_cnt >= 32'(CAN_WD_CYCLES) && s.link != ST_FAULT)
    begin
      n.link = ST_FAULT;
      ev[fieldbus_slave_pkg::IRQ_CAN_FAULT] = 1'b1;
    end

    unique case (s.link)
      ST_DUP_CHECK:
      begin
        n.dup_tx = s.dup_cnt == '0;
        if (pin_sync[1])
          n.link = ST_FAULT;
        else if (s.dup_cnt >= 32'(DUP_CHECK_CYCLES - 1))
          n.link = ST_ONLINE;
        else
          n.dup_cnt = s.dup_cnt + 32'h0000_0001;
      end
      ST_ONLINE, ST_TIMEOUT:
      begin
        // only group 2 requests are accepted by a slave
        if (addressed && msg_group == fieldbus_slave_pkg::GROUP_2 &&
            msg_kind == fieldbus_slave_pkg::MSG_OPEN)
        begin
          n.link = ST_CONNECTED;
          n.wd_cnt = '0;
          n.last_ctrl = '0;
          ev[fieldbus_slave_pkg::IRQ_CONNECT] = 1'b1;
        end
      end
      ST_CONNECTED:
      begin
        if (s.wd_time != '0)
          n.wd_cnt = s.wd_cnt + 32'h0000_0001;
        if (addressed && msg_group == fieldbus_slave_pkg::GROUP_2)
        begin
          if (msg_kind == fieldbus_slave_pkg::MSG_CLOSE)
            n.link = ST_ONLINE;
          else if (msg_kind == fieldbus_slave_pkg::MSG_POLL)
          begin
            n.wd_cnt = '0;
            ctrl = msg_data[3:0];
            rise = ctrl & ~s.last_ctrl;
            n.last_ctrl = ctrl;
            n.pulses = rise;
            if (msg_data[7:4] != 4'h0)
              ev[fieldbus_slave_pkg::IRQ_BAD_CTRL] = 1'b1;
            if (rise != '0)
              ev[fieldbus_slave_pkg::IRQ_CTRL_EVENT] = 1'b1;
            n.tx_valid = 1'b1;
            n.tx_group = fieldbus_slave_pkg::GROUP_1;
            n.tx_kind = fieldbus_slave_pkg::MSG_POLL;
            // byte 0 lsb on the wire first; msb bit 7 carries error
            n.tx_data = {s.err_report, position[30:0]};
          end
        end
        if (s.wd_time != '0 && s.wd_cnt >= s.wd_time)
        begin
          n.link = ST_TIMEOUT;
          ev[fieldbus_slave_pkg::IRQ_TIMEOUT] = 1'b1;
        end
      end
      ST_FAULT:
      begin
        n.link = ST_FAULT;
      end
    endcase

    // attribute requests, handled while online, raw binary bytes
    if (addressed && msg_group == fieldbus_slave_pkg::GROUP_2 &&
        s.link != ST_DUP_CHECK && s.link != ST_FAULT &&
        (msg_kind == fieldbus_slave_pkg::MSG_ATTR_RD ||
         msg_kind == fieldbus_slave_pkg::MSG_ATTR_WR))
    begin
      if (msg_kind == fieldbus_slave_pkg::MSG_ATTR_WR)
        n.attr_value = msg_data;
      n.tx_valid = 1'b1;
      n.tx_group = fieldbus_slave_pkg::GROUP_2;
      n.tx_kind = msg_kind;
      n.tx_data = {16'h0000, fieldbus_slave_pkg::ATTR_OK,
                   msg_kind == fieldbus_slave_pkg::MSG_ATTR_WR ?
                   msg_data : s.attr_value};
      ev[fieldbus_slave_pkg::IRQ_ATTR] = 1'b1;
    end

    // error report: latched, cleared by ack, reasserted if persisting
    if (error_active)
      n.err_report = 1'b1;
    else if (s.auto_ack || n.pulses[fieldbus_slave_pkg::BIT_FAULT_ACK])
      n.err_report = 1'b0;
    if (!s.auto_ack && n.pulses[fieldbus_slave_pkg::BIT_FAULT_ACK])
      n.err_report = error_active;

    // indicators
    n.run = (s.link == ST_CONNECTED) ||
            (s.link == ST_TIMEOUT && s.flash);
    n.err = (s.link == ST_FAULT) ||
            (s.link == ST_TIMEOUT && s.flash);
    n.ok = s.link != ST_FAULT;

    // register bus: one wait cycle, answer on the following edge
    if (bus_req)
    begin
      n.ack = 1'b1;
      n.rdata = '0;
      if (avs_write && avs_byteenable[0])
      begin
        unique case (avs_address)
          fieldbus_slave_pkg::ADDR_CTRL:
            n.auto_ack = avs_writedata[0];
          fieldbus_slave_pkg::ADDR_IRQ_STATUS:
            n.irq_status = s.irq_status & ~avs_writedata[IRQ_W-1:0];
          fieldbus_slave_pkg::ADDR_IRQ_MASK:
            n.irq_mask = avs_writedata[IRQ_W-1:0];
          default:
            n.ack = 1'b1;
        endcase
      end
      if (avs_write && avs_address == fieldbus_slave_pkg::ADDR_WD_TIME)
        n.wd_time = avs_writedata;
      if (avs_read)
      begin
        unique case (avs_address)
          fieldbus_slave_pkg::ADDR_CTRL:
            n.rdata = {31'h0, s.auto_ack};
          fieldbus_slave_pkg::ADDR_STATUS:
            n.rdata = {21'h0, s.err_report, s.node, 1'b0, 3'(s.link)};
          fieldbus_slave_pkg::ADDR_IRQ_STATUS:
            n.rdata = {26'h0, s.irq_status};
          fieldbus_slave_pkg::ADDR_IRQ_MASK:
            n.rdata = {26'h0, s.irq_mask};
          fieldbus_slave_pkg::ADDR_POSITION:
            n.rdata = position;
          fieldbus_slave_pkg::ADDR_LAST_CTRL:
            n.rdata = {28'h0, s.last_ctrl};
          fieldbus_slave_pkg::ADDR_WD_TIME:
            n.rdata = s.wd_time;
          fieldbus_slave_pkg::ADDR_DEVICE_TYPE:
            n.rdata = {24'h0, DEVICE_TYPE};
          fieldbus_slave_pkg::ADDR_ATTR:
            n.rdata = {24'h0, s.attr_value};
          default:
            n.rdata = '0;
        endcase
      end
    end
    // set wins over a same-cycle write-one clear
    n.irq_status = n.irq_status | ev;
    n.irq = (s.irq_status & s.irq_mask) != '0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.link <= ST_DUP_CHECK;
      s.wd_time <= fieldbus_slave_pkg::WD_TIME_RST;
      s.auto_ack <= 1'b1;
    end
    else
      s <= n;
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = !s.ack;
  assign tx_valid = s.tx_valid;
  assign tx_group = s.tx_group;
  assign tx_kind = s.tx_kind;
  assign tx_data = s.tx_data;
  assign dup_check_tx = s.dup_tx;
  assign preset_pulse = s.pulses[fieldbus_slave_pkg::BIT_PRESET];
  assign emitter_off_request = s.pulses[fieldbus_slave_pkg::BIT_EMIT_OFF];
  assign emitter_on_request = s.pulses[fieldbus_slave_pkg::BIT_EMIT_ON];
  assign fault_acknowledge = s.pulses[fieldbus_slave_pkg::BIT_FAULT_ACK];
  assign node_address = s.node;
  assign led_run = s.run;
  assign led_err = s.err;
  assign led_ok = s.ok;
  assign irq = s.irq;
endmodule

// *** test/fieldbus_slave_poll_io_checker.sv ***
// Purpose: port-level assertions for the fieldbus slave block
// Assumes: one clock domain, sync active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module fieldbus_slave_poll_io_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [5:0] address_switch,
  input wire logic msg_valid,
  input wire logic [1:0] msg_group,
  input wire logic [7:0] msg_data,
  input wire logic [31:0] position,
  input wire logic tx_valid,
  input wire logic [1:0] tx_group,
  input wire logic [2:0] tx_kind,
  input wire logic [31:0] tx_data,
  input wire logic dup_check_tx,
  input wire logic preset_pulse,
  input wire logic emitter_off_request,
  input wire logic emitter_on_request,
  input wire logic fault_acknowledge,
  input wire logic [5:0] node_address
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic dup_seen;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dup_seen <= 1'b0;
    else if (dup_check_tx)
      dup_seen <= 1'b1;
  end
  a_reply_cause: assert property (tx_valid |-> $past(msg_valid) &&
    $past(msg_group) == fieldbus_slave_pkg::GROUP_2)
    else $error("reply without group 2 request");
  a_reply_group: assert property (tx_valid &&
    tx_kind == fieldbus_slave_pkg::MSG_POLL |->
    tx_group == fieldbus_slave_pkg::GROUP_1)
    else $error("poll reply not group 1");
  a_preset_bit: assert property (preset_pulse |->
    tx_valid && $past(msg_data[0])) else $error("preset without bit");
  a_off_bit: assert property (emitter_off_request |->
    $past(msg_data[1])) else $error("emitter off without bit");
  a_on_bit: assert property (emitter_on_request |->
    $past(msg_data[2])) else $error("emitter on without bit");
  a_ack_bit: assert property (fault_acknowledge |->
    $past(msg_data[3])) else $error("fault ack without bit");
  a_pos_carry: assert property (tx_valid &&
    tx_kind == fieldbus_slave_pkg::MSG_POLL |->
    tx_data[30:0] == $past(position[30:0])) else $error("position lost");
  a_node_sw: assert property (($stable(address_switch))[*6] |->
    node_address == address_switch) else $error("node address wrong");
  a_dup_first: assert property (tx_valid |-> dup_seen)
    else $error("reply before address check");
  a_bus_ack: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus not acked in one cycle");
endmodule
bind fieldbus_slave_poll_io fieldbus_slave_poll_io_checker chk (.clk,
  .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .address_switch,
  .msg_valid, .msg_group, .msg_data, .position, .tx_valid, .tx_group,
  .tx_kind, .tx_data, .dup_check_tx, .preset_pulse, .emitter_off_request,
  .emitter_on_request, .fault_acknowledge, .node_address);

// *** test/fieldbus_master_model.sv ***
// Purpose: bus master side that sends decoded frames to the slave
// Assumes: one frame per call, one-cycle valid strobe
// Notes: released dest and data lines show inverted values so stale values never match
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire logic clk,
  output logic msg_valid,
  output logic [1:0] msg_group,
  output logic [5:0] msg_dest,
  output logic [2:0] msg_kind,
  output logic [7:0] msg_data
);
  initial
  begin
    msg_valid = 1'b0;
    msg_group = 2'h0;
    msg_dest = 6'h3F;
    msg_kind = 3'h7;
    msg_data = 8'h00;
  end
  // each call is one frame to one node, polls never shared
  task send(input logic [1:0] g, input logic [5:0] a, input logic [2:0] k,
    input logic [7:0] d);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_group <= g;
    msg_dest <= a;
    msg_kind <= k;
    msg_data <= (k == 3'h0) ? {4'h0, d[3:0]} : d;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_dest <= ~a;
    msg_data <= ~d;
  endtask
endmodule

// *** test/fieldbus_slave_poll_io_bench.sv ***
// Purpose: self-checking bench for the fieldbus slave block
// Assumes: shortened dup check, flash and protocol watchdog counts
// Notes: random control bytes and positions from a fixed seed
`timescale 1ns/1ps
module fieldbus_slave_poll_io_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic can_alive = 1'b1;
  logic dup_detected = 1'b0;
  logic error_active = 1'b0;
  logic [31:0] position = 32'h0;
  logic [5:0] address_switch, msg_dest, node_address, sw;
  logic [31:0] avs_readdata, tx_data, q, rx;
  logic [1:0] msg_group, tx_group;
  logic [2:0] msg_kind, tx_kind;
  logic [7:0] msg_data, prev;
  logic [3:0] pul;
  logic msg_valid, avs_waitrequest, tx_valid, dup_check_tx, irq, le;
  logic preset_pulse, emitter_off_request, emitter_on_request;
  logic fault_acknowledge, led_run, led_err, led_ok;
  integer seed = 24016;
  integer n_fail = 0;
  integer checks_done = 0;
  integer n_tx = 0;
  integer n_dup = 0;
  integer i;
  fieldbus_slave_poll_io #(.DUP_CHECK_CYCLES(10), .FLASH_CYCLES(4),
    .CAN_WD_CYCLES(50)) dut (.clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .address_switch, .msg_valid, .msg_group, .msg_dest,
    .msg_kind, .msg_data, .can_alive, .dup_detected, .position,
    .error_active, .tx_valid, .tx_group, .tx_kind, .tx_data, .dup_check_tx,
    .preset_pulse, .emitter_off_request, .emitter_on_request,
    .fault_acknowledge, .node_address, .led_run, .led_err, .led_ok, .irq);
  fieldbus_master_model master (.clk, .msg_valid, .msg_group, .msg_dest,
    .msg_kind, .msg_data);
  initial
    forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1)
    begin
      n_tx++;
      rx = tx_data;
    end
    pul |= {fault_acknowledge, emitter_on_request, emitter_off_request,
      preset_pulse};
    if (dup_check_tx === 1'b1)
      n_dup++;
  end
  function automatic logic [3:0] edges(logic [7:0] cur, logic [7:0] old);
    return cur[3:0] & ~old[3:0];
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    // only the watchdog ends a wait that never answers
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task msg(input logic [1:0] g, input logic [5:0] a, input logic [2:0] k,
    input logic [7:0] d);
    pul = 4'h0;
    n_tx = 0;
    master.send(g, a, k, d);
    repeat (3) @(posedge clk);
  endtask
  task poll(input logic [7:0] d, input logic err);
    logic [3:0] e;
    e = edges(d, prev);
    position <= $random(seed);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h0, d);
    chk("replies", 1, n_tx);
    chk("group", fieldbus_slave_pkg::GROUP_1, tx_group);
    chk("data", {err, position[30:0]}, rx);
    chk("pulses", e, pul);
    prev = d;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    q = $random(seed);
    sw = q[5:0];
    address_switch = sw;
    prev = 8'h00;
    repeat (3) @(posedge clk);
    chk("dark", 0, {led_run, led_err, led_ok});
    sys_rst <= 1'b0;
    repeat (30) @(posedge clk);
    chk("dup msgs", 1, n_dup);
    chk("led ok", 1, led_ok);
    chk("node", sw, node_address);
    bus(0, fieldbus_slave_pkg::ADDR_CTRL, 0);
    chk("ctrl", 1, q);
    bus(0, fieldbus_slave_pkg::ADDR_WD_TIME, 0);
    chk("wd", fieldbus_slave_pkg::WD_TIME_RST, q);
    bus(0, 6'h3C, 0);
    chk("unmapped", 0, q);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("status", {sw, 4'h1}, q[9:0]);
    $display("test reset done");
    msg(fieldbus_slave_pkg::GROUP_1, sw, 3'h1, 0);
    chk("g1 open", 0, n_tx);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h0, 8'h04);
    chk("poll closed", 0, n_tx);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h1, 0);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("open", 2, q[2:0]);
    chk("run", 1, led_run);
    bus(1, fieldbus_slave_pkg::ADDR_IRQ_MASK, 1);
    repeat (2) @(posedge clk);
    chk("irq on", 1, irq);
    bus(1, fieldbus_slave_pkg::ADDR_IRQ_STATUS, 1);
    repeat (2) @(posedge clk);
    chk("irq clr", 0, irq);
    msg(fieldbus_slave_pkg::GROUP_2, sw ^ 6'h01, 3'h0, 0);
    chk("other node", 0, n_tx);
    for (i = 0; i < 12; i++)
    begin
      q = $random(seed);
      // one preset in the whole run keeps presets 500 ms apart
      poll((i == 3 || i == 4) ? 8'h0F : {4'h0, q[3:1], 1'b0}, 0);
    end
    chk("irq masked", 0, irq);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h4, 8'hA5);
    chk("attr rsp", 1, n_tx);
    bus(0, fieldbus_slave_pkg::ADDR_ATTR, 0);
    chk("attr", 8'hA5, q[7:0]);
    $display("test polls done");
    bus(1, fieldbus_slave_pkg::ADDR_CTRL, 0);
    poll(0, 0);
    error_active <= 1'b1;
    poll(0, 1);
    error_active <= 1'b0;
    poll(0, 1);
    // the reply to the acking poll still carries the report held before it
    poll(8'h08, 1);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("err clr", 0, q[10]);
    error_active <= 1'b1;
    poll(0, 1);
    poll(8'h08, 1);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("err held", 1, q[10]);
    error_active <= 1'b0;
    bus(1, fieldbus_slave_pkg::ADDR_CTRL, 1);
    $display("test ack done");
    bus(1, fieldbus_slave_pkg::ADDR_WD_TIME, 20);
    poll(0, 0);
    repeat (40) @(posedge clk);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("timeout", 3, q[2:0]);
    i = 0;
    le = led_err;
    repeat (30)
    begin
      @(posedge clk);
      if (led_err !== le)
        i++;
      le = led_err;
    end
    chk("flash", 1, i > 2);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h1, 0);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("reopen", 2, q[2:0]);
    bus(1, fieldbus_slave_pkg::ADDR_WD_TIME, 0);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h2, 0);
    msg(fieldbus_slave_pkg::GROUP_2, sw, 3'h0, 0);
    chk("closed", 0, n_tx);
    can_alive <= 1'b0;
    repeat (80) @(posedge clk);
    bus(0, fieldbus_slave_pkg::ADDR_STATUS, 0);
    chk("can fault", 4, q[2:0]);
    chk("err led", 1, led_err);
    $display("test link done");
    tally_and_finish;
  end
endmodule
